// ### bdtrp_device.sv
// Summary of operation
// - two planes fetched as 32 bits, 16-bit words out
// - bursts are reads only, never writes
// - burst clock ignored unless burst enabled
// - invert bit picks sampling edge polarity
// - inverted clock adds half cycle, rising output
// - external reset clears burst enable
// - first word latency plus two, then per clock
// - hold keeps each word two clocks
// - host reads exactly programmed burst length
// - halted clock needs latency plus two cycles
// - one rise per word, two with hold
// - dma moves up to 256 sectors (128KB) by pages
// - request shows page ready, interrupt error/end
// - edge mode pulses request low 250ns+
// - level mode holds request through block
// - host dma moves 512 bytes per request
// - control write raises first dma request
// - ecc error interrupts and stops, else request
// - interrupt after last sector read
// - extra request after final byte, host clears
// - clearing enable stops at sector boundary
// - host does seven nops, then burst off; the bench skips the nops and only turns burst off
// - turbo drives data once selected
`timescale 1ns/1ps
`default_nettype none
module bdtrp_fifo #(
  parameter int W = 32,
  parameter int D = 8
) (
  input  wire logic         clock,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(D);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } bdtrp_fifo_st_t;
  bdtrp_fifo_st_t s, n;
  logic [W-1:0] mem [D];
  logic         push;
  logic         pop;

  assign in_ready  = (s.cnt != FULL_CNT);
  assign out_valid = (s.cnt != '0);
  assign out_data  = mem[s.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_ready & out_valid;

  always_comb begin
    n = s;
    if (push) begin
      n.wp = s.wp + 1'b1;
    end
    if (pop) begin
      n.rp = s.rp + 1'b1;
    end
    if (push & ~pop) begin
      n.cnt = s.cnt + 1'b1;
    end else if (pop & ~push) begin
      n.cnt = s.cnt - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[s.wp] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule

module bdtrp_device (
  input  wire logic                          clock,
  input  wire logic                          reset_n,
  bdtrp_if.device                            link,
  input  wire logic [bdtrp_pkg::FLASH_W-1:0] flash_data,
  input  wire logic                          flash_valid,
  output logic                               flash_ready,
  input  wire logic                          cfg_write,
  input  wire logic                          cfg_burst_en,
  input  wire logic                          burst_clock_invert_bit,
  input  wire logic [bdtrp_pkg::LAT_W-1:0]   cfg_latency,
  input  wire logic                          cfg_hold,
  input  wire logic [bdtrp_pkg::LEN_W-1:0]   cfg_length,
  input  wire logic                          cfg_turbo,
  input  wire logic                          dma_write,
  input  wire logic                          dma_enable,
  input  wire logic                          dma_edge,
  input  wire logic [bdtrp_pkg::SEC_W-1:0]   dma_sectors,
  input  wire logic                          ecc_error,
  input  wire logic                          irq_ack,
  output logic                               burst_read_mode
);
  typedef struct packed {
    logic clk_m, clk_s, clk_p;
    logic ce_m, ce_s, oe_m, oe_s, xr_m, xr_s;
    logic burst_en, inv, hold, turbo;
    logic [bdtrp_pkg::LAT_W-1:0] lat;
    logic [bdtrp_pkg::LEN_W-1:0] len;
    bdtrp_pkg::bdtrp_bst_t       bst;
    logic [bdtrp_pkg::CNT_W-1:0] cnt;
    logic [bdtrp_pkg::LEN_W-1:0] words;
    logic                        half, pop, shown, dout_oe_n;
    logic [bdtrp_pkg::WORD_W-1:0] dout;
    bdtrp_pkg::bdtrp_dst_t       dst;
    logic                        dma_en, edge_mode, last, ecc;
    logic [bdtrp_pkg::SEC_W-1:0] secs;
    logic [bdtrp_pkg::SWC_W-1:0] swords;
    logic [bdtrp_pkg::PULSE_W-1:0] pulse;
    logic                        dma_request_n_n, irq_n;
  } bdtrp_dev_st_t;
  bdtrp_dev_st_t s, n;

  logic [bdtrp_pkg::FLASH_W-1:0] fifo_data;
  logic                          fifo_valid;

  // a few flash words of slack so the page fetch can run ahead
  bdtrp_fifo #(.W(bdtrp_pkg::FLASH_W), .D(bdtrp_pkg::FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .reset_n   (reset_n),
    .in_data   (flash_data),
    .in_valid  (flash_valid),
    .in_ready  (flash_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (s.pop)
  );

  assign link.data_out      = s.dout;
  assign link.data_oe_n     = s.dout_oe_n;
  assign link.dma_request_n = s.dma_request_n_n;
  assign link.irq_n         = s.irq_n;
  assign burst_read_mode    = s.burst_en;

  always_comb begin
    logic rise;
    logic fall;
    logic sel;
    logic present;
    logic sec_end;
    rise    = s.clk_s & ~s.clk_p;
    fall    = ~s.clk_s & s.clk_p;
    sel     = ~s.ce_s & ~s.oe_s;
    present = 1'b0;
    sec_end = 1'b0;
    n       = s;
    n.pop   = 1'b0;
    n.clk_m = link.burst_clk;
    n.clk_s = s.clk_m;
    n.clk_p = s.clk_s;
    n.ce_m  = link.ce_n;
    n.ce_s  = s.ce_m;
    n.oe_m  = link.oe_n;
    n.oe_s  = s.oe_m;
    n.xr_m  = link.external_reset_n;
    n.xr_s  = s.xr_m;

    if (cfg_write) begin
      n.burst_en = cfg_burst_en;
      n.inv      = burst_clock_invert_bit;
      n.lat      = cfg_latency;
      n.hold     = cfg_hold;
      n.len      = cfg_length;
      n.turbo    = cfg_turbo;
    end
    if (!s.xr_s) begin
      n.burst_en = 1'b0;
    end

    case (s.bst)
      bdtrp_pkg::B_IDLE: begin
        n.shown = 1'b0;
        if (sel && s.burst_en) begin
          n.bst = bdtrp_pkg::B_ARMED;
        end else if (sel) begin
          present = 1'b1; // burst clock ignored for plain reads
          n.bst   = bdtrp_pkg::B_HELD;
        end
      end
      bdtrp_pkg::B_ARMED: begin
        if (!sel) begin
          n.bst = bdtrp_pkg::B_IDLE;
        end else if (s.inv ? fall : rise) begin
          n.cnt   = bdtrp_pkg::LAT_BASE + {1'b0, s.lat};
          if (s.inv) begin
            n.cnt = n.cnt + bdtrp_pkg::INV_EXTRA;
          end
          n.words = '0;
          n.bst   = bdtrp_pkg::B_RUN;
        end
      end
      bdtrp_pkg::B_RUN: begin
        if (!sel) begin
          n.bst = bdtrp_pkg::B_IDLE;
        end else if (rise) begin // words leave on rising edges only
          if (s.cnt == bdtrp_pkg::CNT_FIRE) begin
            present = 1'b1;
            n.cnt   = s.hold ? bdtrp_pkg::STEP_HOLD
                             : bdtrp_pkg::STEP_PLAIN;
            n.words = s.words + 1'b1;
            if (n.words == s.len) begin
              n.bst = bdtrp_pkg::B_HELD;
            end
          end else begin
            n.cnt = s.cnt - 1'b1;
          end
        end
      end
      default: begin
        if (!sel) begin
          n.bst = bdtrp_pkg::B_IDLE;
        end
      end
    endcase
    if (!s.xr_s) begin
      n.bst = bdtrp_pkg::B_IDLE;
    end

    // low half first, the 32-bit entry is popped with the high half
    if (present) begin
      n.dout  = s.half ? fifo_data[bdtrp_pkg::FLASH_W-1:bdtrp_pkg::WORD_W]
                       : fifo_data[bdtrp_pkg::WORD_W-1:0];
      n.half  = ~s.half;
      n.pop   = s.half & fifo_valid;
      n.shown = 1'b1;
    end
    // read-only port: the bus is only ever driven outward
    n.dout_oe_n = ~(sel & (s.turbo | n.shown));

    if (ecc_error) begin
      n.ecc = 1'b1;
    end
    if (dma_write) begin
      n.dma_en = dma_enable; // takes effect at sector end
    end
    if (irq_ack) begin
      n.irq_n = 1'b1;
    end

    case (s.dst)
      bdtrp_pkg::D_IDLE: begin
        if (dma_write && dma_enable) begin
          n.edge_mode = dma_edge;
          n.secs      = dma_sectors;
          n.swords    = '0;
          n.ecc       = ecc_error;
          n.last      = 1'b0;
          n.dst       = bdtrp_pkg::D_REQ;
          n.dma_request_n_n   = 1'b0;
          n.pulse     = bdtrp_pkg::PULSE_CNT;
        end
      end
      bdtrp_pkg::D_REQ: begin
        if (s.edge_mode || s.last) begin
          n.pulse = s.pulse - 1'b1;
          if (s.pulse == bdtrp_pkg::PULSE_W'(1)) begin
            n.dma_request_n_n = 1'b1;
            n.dst     = s.last ? bdtrp_pkg::D_IDLE : bdtrp_pkg::D_WAIT;
          end
        end
        // level mode idles one cycle at a block end, then asserts again
        if (!s.edge_mode && s.dma_request_n_n) begin
          n.dma_request_n_n = 1'b0;
          n.pulse   = bdtrp_pkg::PULSE_CNT;
        end
        sec_end = present & ~s.last; // level request stays low
      end
      default: begin
        sec_end = present;
      end
    endcase

    if (sec_end) begin
      n.swords = s.swords + 1'b1;
      if (s.swords == bdtrp_pkg::SECTOR_LAST) begin
        n.swords  = '0;
        n.ecc     = ecc_error;
        n.dma_request_n_n = 1'b1;
        n.dst     = bdtrp_pkg::D_IDLE;
        if (s.ecc || ecc_error) begin
          n.irq_n = 1'b0;
        end else if (s.secs == bdtrp_pkg::SEC_W'(1)) begin
          n.irq_n   = 1'b0;
          n.last    = 1'b1; // trailing request
          n.dst     = bdtrp_pkg::D_REQ;
          n.dma_request_n_n = ~s.edge_mode;
          n.pulse   = bdtrp_pkg::PULSE_CNT;
        end else if (s.dma_en) begin
          n.secs    = s.secs - 1'b1;
          n.dst     = bdtrp_pkg::D_REQ;
          n.dma_request_n_n = ~s.edge_mode;
          n.pulse   = bdtrp_pkg::PULSE_CNT;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s           <= '0;
      s.clk_m     <= 1'b0;
      s.ce_m      <= 1'b1;
      s.ce_s      <= 1'b1;
      s.oe_m      <= 1'b1;
      s.oe_s      <= 1'b1;
      s.dout_oe_n <= 1'b1;
      s.dma_request_n_n   <= 1'b1;
      s.irq_n     <= 1'b1;
      s.bst       <= bdtrp_pkg::B_IDLE;
      s.dst       <= bdtrp_pkg::D_IDLE;
    end else begin
      s <= n;
    end
  end
endmodule
`default_nettype wire

// ### bdtrp_host.sv
// host end: makes the burst clock, reads bursts, watches dma pins
`timescale 1ns/1ps
`default_nettype none
module bdtrp_host (
  input  wire logic                         clock,
  input  wire logic                         reset_n,
  bdtrp_if.host                             link,
  input  wire logic                         cmd_valid,
  input  wire logic [bdtrp_pkg::LEN_W-1:0]  cmd_words,
  input  wire logic [bdtrp_pkg::LAT_W-1:0]  cmd_latency,
  input  wire logic                         cmd_hold,
  input  wire logic                         cmd_invert,
  output logic                              cmd_ready,
  output logic [bdtrp_pkg::WORD_W-1:0]      word_data,
  output logic                              word_valid,
  input  wire logic                         reset_request,
  output logic                              dma_req_pulse,
  output logic                              dma_req_level,
  output logic                              irq_active
);
  typedef struct packed {
    bdtrp_pkg::bdtrp_hst_t        hst;
    logic [bdtrp_pkg::CNT_W-1:0]  div;
    logic                         clk, ce_n, oe_n, xr_n, rdy;
    logic [bdtrp_pkg::LAT_W-1:0]  lat;
    logic                         hold, inv, sampled, pend;
    logic [bdtrp_pkg::LEN_W-1:0]  left;
    logic [bdtrp_pkg::CNT_W-1:0]  cnt;
    logic [bdtrp_pkg::WORD_W-1:0] d_m, d_s, wdata;
    logic                         wvalid;
    logic                         rq_m, rq_s, rq_p, rq_pulse;
    logic                         irq_m, irq_s;
  } bdtrp_host_st_t;
  bdtrp_host_st_t s, n;

  assign link.burst_clk        = s.clk;
  assign link.ce_n             = s.ce_n;
  assign link.oe_n             = s.oe_n;
  assign link.external_reset_n = s.xr_n;
  assign cmd_ready             = s.rdy;
  assign word_data             = s.wdata;
  assign word_valid            = s.wvalid;
  assign dma_req_pulse         = s.rq_pulse;
  assign dma_req_level         = ~s.rq_p;
  assign irq_active            = ~s.irq_s;

  always_comb begin
    logic tick;
    tick       = (s.div == bdtrp_pkg::LINK_HALF - 1'b1);
    n          = s;
    n.wvalid   = 1'b0;
    n.d_m      = link.data_bus;
    n.d_s      = s.d_m;
    n.rq_m     = link.dma_request_n;
    n.rq_s     = s.rq_m;
    n.rq_p     = s.rq_s;
    n.rq_pulse = s.rq_p & ~s.rq_s; // edge request: move one page
    n.irq_m    = link.irq_n;
    n.irq_s    = s.irq_m;
    n.xr_n     = ~reset_request;

    case (s.hst)
      bdtrp_pkg::H_IDLE: begin
        if (cmd_valid && s.rdy && cmd_words != '0) begin
          n.rdy     = 1'b0;
          n.ce_n    = 1'b0;
          n.oe_n    = 1'b0;
          n.lat     = cmd_latency;
          n.hold    = cmd_hold;
          n.inv     = cmd_invert;
          n.left    = cmd_words; // must match device length
          n.div     = '0;
          n.sampled = 1'b0;
          n.pend    = 1'b0;
          n.hst     = bdtrp_pkg::H_SETUP;
        end
      end
      bdtrp_pkg::H_SETUP: begin
        // let the device's synchronisers see the select first
        n.div = s.div + 1'b1;
        if (s.div == bdtrp_pkg::SEL_SETUP - 1'b1) begin
          n.div = '0;
          n.hst = bdtrp_pkg::H_RUN;
        end
      end
      default: begin
        n.div = s.div + 1'b1;
        if (tick) begin
          n.div = '0;
          n.clk = ~s.clk;
          if (!s.clk) begin
            if (!s.sampled && !s.inv) begin
              n.sampled = 1'b1;
              n.cnt     = bdtrp_pkg::LAT_BASE + {1'b0, s.lat};
            end else if (s.sampled) begin
              if (s.cnt == bdtrp_pkg::CNT_FIRE) begin
                n.pend = 1'b1;
                n.cnt  = s.hold ? bdtrp_pkg::STEP_HOLD
                                : bdtrp_pkg::STEP_PLAIN;
              end else begin
                n.cnt = s.cnt - 1'b1;
              end
            end
          end else if (!s.sampled && s.inv) begin
            n.sampled = 1'b1;
            n.cnt     = bdtrp_pkg::LAT_BASE + {1'b0, s.lat}
                        + bdtrp_pkg::INV_EXTRA;
          end else if (s.pend) begin
            n.pend   = 1'b0;
            n.wvalid = 1'b1;
            n.wdata  = s.d_s;
            n.left   = s.left - 1'b1;
            if (s.left == bdtrp_pkg::LEN_W'(1)) begin
              // stop on the low phase: no edge for the last word
              n.ce_n = 1'b1;
              n.oe_n = 1'b1;
              n.rdy  = 1'b1;
              n.hst  = bdtrp_pkg::H_IDLE;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s       <= '0;
      s.hst   <= bdtrp_pkg::H_IDLE;
      s.ce_n  <= 1'b1;
      s.oe_n  <= 1'b1;
      s.xr_n  <= 1'b1;
      s.rdy   <= 1'b1;
      s.rq_m  <= 1'b1;
      s.rq_s  <= 1'b1;
      s.rq_p  <= 1'b1;
      s.irq_m <= 1'b1;
      s.irq_s <= 1'b1;
    end else begin
      s <= n;
    end
  end
endmodule
`default_nettype wire

// ### bdtrp_if.sv
// pins between the flash read port and its host
`timescale 1ns/1ps
`default_nettype none
interface bdtrp_if;
  logic                        burst_clk;
  logic                        ce_n;
  logic                        oe_n;
  logic                        external_reset_n;
  logic                        dma_request_n;
  logic                        irq_n;
  logic                        data_oe_n;
  logic [bdtrp_pkg::WORD_W-1:0] data_out;
  logic [bdtrp_pkg::WORD_W-1:0] data_bus;

  // undriven bus floats high through the board pull-ups
  assign data_bus = data_oe_n ? bdtrp_pkg::BUS_IDLE : data_out;

  modport device (input burst_clk, ce_n, oe_n, external_reset_n,
                  output dma_request_n, irq_n, data_out, data_oe_n);
  modport host (output burst_clk, ce_n, oe_n, external_reset_n,
                input dma_request_n, irq_n, data_bus);
endinterface
`default_nettype wire

// ### bdtrp_pkg.sv
// shared constants and types for the burst and dma read port
package bdtrp_pkg;
  localparam int CLK_NS        = 10;
  localparam int DMA_PULSE_NS  = 250;
  localparam int DMA_PULSE_CYC = (DMA_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_W       = 5;
  localparam int FLASH_W       = 32;
  localparam int WORD_W        = 16;
  localparam int FIFO_DEPTH    = 8;
  localparam int LAT_W         = 3;
  localparam int LEN_W         = 8;
  localparam int SEC_W         = 8;
  localparam int SWC_W         = 9;
  localparam int CNT_W         = 4;

  localparam logic [CNT_W-1:0] LAT_BASE    = 4'h2;
  localparam logic [CNT_W-1:0] INV_EXTRA   = 4'h1;
  localparam logic [CNT_W-1:0] STEP_PLAIN  = 4'h1;
  localparam logic [CNT_W-1:0] STEP_HOLD   = 4'h2;
  localparam logic [CNT_W-1:0] CNT_FIRE    = 4'h1;
  localparam logic [CNT_W-1:0] LINK_HALF   = 4'h8;
  localparam logic [CNT_W-1:0] SEL_SETUP   = 4'h4;
  localparam logic [SWC_W-1:0] SECTOR_LAST = 9'h0ff;
  localparam logic [PULSE_W-1:0] PULSE_CNT = PULSE_W'(DMA_PULSE_CYC);
  localparam logic [WORD_W-1:0]  BUS_IDLE  = 16'hffff;

  typedef enum logic [1:0] {B_IDLE, B_ARMED, B_RUN, B_HELD} bdtrp_bst_t;
  typedef enum logic [1:0] {D_IDLE, D_REQ, D_WAIT} bdtrp_dst_t;
  typedef enum logic [1:0] {H_IDLE, H_SETUP, H_RUN} bdtrp_hst_t;
endpackage

// ### bdtrp_properties.sv
// link assertions for the burst and dma read port
`timescale 1ns/1ps
`default_nettype none
module bdtrp_properties (
  input wire logic                         clock,
  input wire logic                         reset_n,
  input wire logic                         burst_clk,
  input wire logic                         ce_n,
  input wire logic                         oe_n,
  input wire logic                         external_reset_n,
  input wire logic                         dma_request_n,
  input wire logic                         irq_n,
  input wire logic                         data_oe_n,
  input wire logic [bdtrp_pkg::WORD_W-1:0] data_out,
  input wire logic                         dma_edge,
  input wire logic                         dma_write,
  input wire logic                         dma_enable,
  input wire logic                         irq_ack,
  input wire logic                         cfg_turbo,
  input wire logic                         burst_read_mode
);
  logic [7:0] low_cnt_q;
  logic [4:0] rise_age_q;
  logic       clk_prev_q;

  // saturating, so long idle stretches never wrap into a false match
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt_q  <= 8'h00;
      rise_age_q <= 5'h1f;
      clk_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= burst_clk;
      if (dma_request_n) begin
        low_cnt_q <= 8'h00;
      end else if (low_cnt_q != 8'hff) begin
        low_cnt_q <= low_cnt_q + 8'h01;
      end
      if (burst_clk && !clk_prev_q) begin
        rise_age_q <= 5'h00;
      end else if (rise_age_q != 5'h1f) begin
        rise_age_q <= rise_age_q + 5'h01;
      end
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_edge_pulse_len: assert property (
    $rose(dma_request_n) && dma_edge |-> low_cnt_q == 8'h19)
    else $error("edge request pulse not 25 cycles");
  a_level_low_min: assert property (
    $rose(dma_request_n) && !dma_edge |-> low_cnt_q >= 8'h19)
    else $error("level request released early");
  a_irq_stays_low: assert property (
    !irq_n && !irq_ack && !$past(irq_ack) |=> !irq_n)
    else $error("interrupt dropped without ack");
  a_dma_first_req: assert property (
    dma_write && dma_enable |=> !dma_request_n)
    else $error("no request after dma start");
  a_turbo_drive_on: assert property (
    $fell(oe_n) && !ce_n && cfg_turbo |-> ##[1:6] !data_oe_n)
    else $error("turbo did not drive data after select");
  a_ext_reset_burst: assert property (
    !external_reset_n [*5] |-> !burst_read_mode)
    else $error("burst mode kept under external reset");
  a_plain_word_held: assert property (
    !burst_read_mode && !data_oe_n && !$past(data_oe_n) |-> $stable(data_out))
    else $error("word changed with burst mode off");
  a_data_on_rise: assert property (
    !data_oe_n && !$past(data_oe_n) && $changed(data_out) |->
      rise_age_q <= 5'h06)
    else $error("data word not launched by a rising clock");
endmodule
`default_nettype wire

// ### burst_dma_turbo_read_port_tb_top.sv
// bench: host end reads bursts and dma sectors from the device end
`timescale 1ns/1ps
`default_nettype none
module burst_dma_turbo_read_port_tb_top;
  logic        clock, reset_n, flash_valid, flash_ready, cfg_write;
  logic        cfg_burst_en, inv, hold, turbo, dma_write, dma_enable;
  logic        dma_edge, ecc_error, irq_ack, burst_read_mode, cmd_valid;
  logic        cmd_ready, word_valid, reset_request, dma_req_pulse;
  logic        dma_req_level, irq_active, feed_on, mon_on;
  logic [2:0]  lat;
  logic [7:0]  len, dma_sectors;
  logic [15:0] word_data, fidx, widx, last_w, prev_w;
  logic [31:0] flash_data;
  int          num_errors, n_tests, req_cnt, cycles;
  // {invert, latency, hold, length}
  localparam logic [12:0] COMBOS [4] = '{13'h0003, 13'h0f02, 13'h1605,
                                         13'h1b01};

  bdtrp_if link ();
  bdtrp_device i_bdtrp_device (
    .clock(clock), .reset_n(reset_n), .link(link.device),
    .flash_data(flash_data), .flash_valid(flash_valid),
    .flash_ready(flash_ready), .cfg_write(cfg_write),
    .cfg_burst_en(cfg_burst_en), .burst_clock_invert_bit(inv),
    .cfg_latency(lat), .cfg_hold(hold), .cfg_length(len),
    .cfg_turbo(turbo), .dma_write(dma_write), .dma_enable(dma_enable),
    .dma_edge(dma_edge), .dma_sectors(dma_sectors),
    .ecc_error(ecc_error), .irq_ack(irq_ack),
    .burst_read_mode(burst_read_mode));
  bdtrp_host i_bdtrp_host (
    .clock(clock), .reset_n(reset_n), .link(link.host),
    .cmd_valid(cmd_valid), .cmd_words(len), .cmd_latency(lat),
    .cmd_hold(hold), .cmd_invert(inv), .cmd_ready(cmd_ready),
    .word_data(word_data), .word_valid(word_valid),
    .reset_request(reset_request), .dma_req_pulse(dma_req_pulse),
    .dma_req_level(dma_req_level), .irq_active(irq_active));
  bdtrp_properties i_bdtrp_properties (
    .clock(clock), .reset_n(reset_n), .burst_clk(link.burst_clk),
    .ce_n(link.ce_n), .oe_n(link.oe_n),
    .external_reset_n(link.external_reset_n),
    .dma_request_n(link.dma_request_n), .irq_n(link.irq_n),
    .data_oe_n(link.data_oe_n), .data_out(link.data_out),
    .dma_edge(dma_edge), .dma_write(dma_write), .dma_enable(dma_enable),
    .irq_ack(irq_ack), .cfg_turbo(turbo),
    .burst_read_mode(burst_read_mode));

  // flash word n carries halves 2n and 2n+1, so the word stream is a count
  assign flash_valid = feed_on;
  assign flash_data  = {fidx[14:0], 1'b1, fidx[14:0], 1'b0} ^ 32'h5a005a00;

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic check(input logic ok, input string what);
    n_tests = n_tests + 1;
    if (ok !== 1'b1) begin
      num_errors = num_errors + 1;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (flash_valid && flash_ready) fidx <= fidx + 16'h0001;
    if (dma_req_pulse === 1'b1) req_cnt <= req_cnt + 1;
    if (word_valid === 1'b1) begin
      widx   <= widx + 16'h0001;
      last_w <= word_data;
      prev_w <= last_w;
      if (mon_on) check(word_data === (widx ^ 16'h5a00), "word");
    end
    if (cycles == 40000) begin
      check(1'b0, "run timed out");
      print_verdict();
    end
  end

  task automatic set_cfg(input logic en, input logic ci, input logic [2:0] cl,
                         input logic ch, input logic [7:0] cn,
                         input logic ct);
    cfg_burst_en <= en;
    inv          <= ci;
    lat          <= cl;
    hold         <= ch;
    len          <= cn;
    turbo        <= ct;
    cfg_write    <= 1'b1;
    tick(1);
    cfg_write    <= 1'b0;
    tick(1);
  endtask

  task automatic burst();
    logic [15:0] w0;
    w0 = widx;
    cmd_valid <= 1'b1;
    tick(1);
    while (cmd_ready !== 1'b1) tick(1);
    cmd_valid <= 1'b0;
    tick(2);
    while (cmd_ready !== 1'b1) tick(1);
    tick(2);
    check((widx - w0) === {8'h00, len}, "word count");
  endtask

  task automatic dma_cmd(input logic en, input logic ed, input logic [7:0] n);
    dma_enable  <= en;
    dma_edge    <= ed;
    dma_sectors <= n;
    dma_write   <= 1'b1;
    tick(1);
    dma_write   <= 1'b0;
  endtask

  task automatic wait_req(input int n);
    int k;
    for (k = 0; k < 300 && req_cnt < n; k++) tick(1);
    check(req_cnt >= n, "request missing");
  endtask

  task automatic ack_irq();
    irq_ack <= 1'b1;
    tick(1);
    irq_ack <= 1'b0;
    tick(6);
    check(irq_active === 1'b0, "irq not cleared");
  endtask

  initial begin
    int r;
    {reset_n, cfg_write, cfg_burst_en, inv, hold, turbo} = '0;
    {dma_write, dma_enable, dma_edge, ecc_error, irq_ack, cmd_valid} = '0;
    {reset_request, feed_on, lat, len, dma_sectors} = '0;
    {fidx, widx, last_w, prev_w} = '0;
    {num_errors, n_tests, req_cnt, cycles} = '0;
    mon_on = 1'b1;
    tick(2);
    reset_n <= 1'b1;
    tick(1);
    check(link.dma_request_n === 1'b1 && link.irq_n === 1'b1, "idle");
    check(link.data_bus === 16'hffff, "bus driven at idle");
    feed_on <= 1'b1;
    tick(30);
    check(flash_ready === 1'b0, "fifo never refused");
    foreach (COMBOS[i]) begin
      set_cfg(1'b1, COMBOS[i][12], COMBOS[i][11:9], COMBOS[i][8],
              COMBOS[i][7:0], 1'(i == 3));
      burst();
    end
    // drain to a whole-word boundary: one more half would show a stale word
    feed_on <= 1'b0;
    set_cfg(1'b1, 1'b0, 3'h0, 1'b0, 8'h10 - {7'h00, widx[0]}, 1'b0);
    burst();
    check(flash_ready === 1'b1, "fifo not drained");
    feed_on <= 1'b1;
    set_cfg(1'b1, 1'b0, 3'h0, 1'b0, 8'h80, 1'b0);
    r = req_cnt;
    dma_cmd(1'b1, 1'b1, 8'h02);
    tick(1);
    check(link.dma_request_n === 1'b0, "no first request");
    tick(30);
    check(link.dma_request_n === 1'b1, "request pulse too long");
    wait_req(r + 1);
    burst();
    burst();
    wait_req(r + 2);
    burst();
    burst();
    wait_req(r + 3);
    tick(60);
    check(irq_active === 1'b1 && req_cnt == r + 3, "end of dma");
    ack_irq();
    r = req_cnt;
    dma_cmd(1'b1, 1'b0, 8'h03);
    wait_req(r + 1);
    burst();
    check(dma_req_level === 1'b1, "level request dropped");
    burst();
    wait_req(r + 2);
    ecc_error <= 1'b1;
    tick(1);
    ecc_error <= 1'b0;
    burst();
    burst();
    tick(100);
    check(irq_active === 1'b1 && dma_req_level === 1'b0, "ecc stop");
    check(req_cnt == r + 2, "request after ecc");
    // the block has no no-op register, so the host only drops burst mode
    set_cfg(1'b0, 1'b0, 3'h0, 1'b0, 8'h80, 1'b0);
    check(burst_read_mode === 1'b0, "burst mode left on");
    ack_irq();
    set_cfg(1'b1, 1'b0, 3'h0, 1'b0, 8'h80, 1'b0);
    r = req_cnt;
    dma_cmd(1'b1, 1'b1, 8'h04);
    wait_req(r + 1);
    dma_cmd(1'b0, 1'b1, 8'h04);
    burst();
    burst();
    tick(100);
    check(req_cnt == r + 1, "request after abort");
    set_cfg(1'b0, 1'b0, 3'h0, 1'b0, 8'h02, 1'b0);
    mon_on <= 1'b0;
    burst();
    check(last_w === prev_w, "plain read moved");
    set_cfg(1'b1, 1'b0, 3'h0, 1'b0, 8'h02, 1'b0);
    tick(2);
    check(burst_read_mode === 1'b1, "burst mode not set");
    reset_request <= 1'b1;
    tick(8);
    check(burst_read_mode === 1'b0, "burst mode kept");
    reset_request <= 1'b0;
    tick(4);
    print_verdict();
  end
endmodule
`default_nettype wire
